/* core/swp_pkg.sv */
// Shared constants for the sector write-protect decoder
package swp_pkg;
    // Register byte offsets on the AHB-Lite bus
    localparam logic [7:0] OFS_PROT_CFG = 8'h00;
    localparam logic [7:0] OFS_DENSITY = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;

    // Protection register field positions (status register layout)
    localparam int BIT_LEVEL0 = 2;
    localparam int BIT_LEVEL1 = 3;
    localparam int BIT_LEVEL2 = 4;
    localparam int BIT_TOP_BOTTOM = 5;
    localparam int BIT_LEVEL3 = 6;

    // Result register field positions
    localparam int BIT_LAST_ACCEPT = 0;
    localparam int BIT_LAST_REJECT = 1;
    localparam int BIT_ANY_LEVEL = 2;

    // Values after reset
    localparam logic [4:0] PROT_RST = 5'h00;
    localparam logic [1:0] DENSITY_RST = 2'h0;

    // Density codes
    localparam logic [1:0] DENS_32 = 2'h0;
    localparam logic [1:0] DENS_64 = 2'h1;
    localparam logic [1:0] DENS_128 = 2'h2;

    // Smallest density has 2**5 sectors
    localparam logic [3:0] LOG2_BASE = 4'h5;
    localparam int SECTOR_W = 7;

    // Command kinds from the write and erase logic
    typedef enum logic [1:0] {
        KIND_WRITE_BYTE = 2'h0,
        KIND_SECTOR_ERASE = 2'h1,
        KIND_BULK_ERASE = 2'h2,
        KIND_DIE_ERASE = 2'h3
    } swp_kind_t;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* core/swp_range_dec.sv */
// Combinational decode of the protected sector range
`timescale 1ns/1ps
module swp_range_dec
(
    input wire logic [1:0] density,
    input wire logic top_bottom_select,
    input wire logic [3:0] level,
    input wire logic [swp_pkg::SECTOR_W-1:0] sector,
    output logic sector_protected,
    output logic sector_valid
);
    import swp_pkg::*;

    logic [3:0] code;
    logic [3:0] log2_n;
    logic [3:0] shift;
    logic [8:0] num_sectors;
    logic [8:0] count;
    logic [8:0] sec9;
    logic full;

    // Smaller parts ignore the fourth level bit
    function automatic logic [3:0] eff_code(input logic [1:0] dens, input logic [3:0] lv);
        if (dens == DENS_32 || dens == DENS_64) begin
            eff_code = {1'b0, lv[2:0]}; // see RQ7
        end else begin
            eff_code = lv;
        end
    endfunction

    always_comb begin
        code = eff_code(density, level);
        // Reserved density code 3 decodes as the 128-sector part
        log2_n = LOG2_BASE + ((density == 2'h3) ? 4'(DENS_128) : 4'(density));
        num_sectors = 9'h001 << log2_n;
        shift = code - 4'h1;
        // A range that reaches the array size covers everything
        full = (code != 4'h0) && (shift >= log2_n); // see RQ1 see RQ2 see RQ3 see RQ4 see RQ5
        count = full ? num_sectors : (9'h001 << shift);
        sec9 = {2'h0, sector};
        sector_valid = sec9 < num_sectors;
        if (code == 4'h0) begin
            sector_protected = 1'b0; // see RQ6
        end else if (full) begin
            sector_protected = 1'b1;
        end else if (top_bottom_select) begin
            sector_protected = sec9 < count; // see RQ8 see RQ2 see RQ4
        end else begin
            sector_protected = sec9 >= (num_sectors - count); // see RQ8 see RQ1 see RQ3 see RQ5
        end
    end
endmodule

/* core/swp_protect_top.sv */
// Sector write-protect decoder with AHB-Lite registers and command check port
// Functional notes
// RQ1 - 32 sectors, top: codes 1..5 guard highest 1..16 sectors; 6,7 guard all.
// RQ2 - 32 sectors, bottom: codes 1..5 guard lowest 1..16 sectors; 6,7 guard all.
// RQ3 - 64 sectors, top: codes 1..6 guard highest 1..32 sectors; 7 guards all.
// RQ4 - 64 sectors, bottom: codes 1..6 guard lowest 1..32 sectors; 7 guards all.
// RQ5 - 128 sectors use four level bits; top codes 1..7 guard 1..64; MSB set guards all.
// RQ6 - Sectors outside the guarded range are free; level code zero guards nothing.
// RQ7 - The two smaller densities decode only three level bits.
// RQ8 - Top/bottom select 1 puts the range at sector 0, 0 at the top.
// RQ9 - Byte writes and sector erases into a guarded sector are rejected.
// RQ10 - Bulk and die erases pass only while every level bit is zero.
// RQ11 - Decode is combinational so new settings apply to the next command.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module swp_protect_top
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CMD_VALID,
    input wire logic [1:0] CMD_KIND,
    input wire logic [swp_pkg::SECTOR_W-1:0] CMD_SECTOR,
    output logic CMD_ACCEPT,
    output logic CMD_REJECT
);
    import swp_pkg::*;

    logic [4:0] prot_q, prot_d;
    logic [1:0] dens_q, dens_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q;
    logic accept_q, accept_d;
    logic reject_q, reject_d;
    logic last_acc_q, last_acc_d;
    logic last_rej_q, last_rej_d;

    logic addr_phase;
    logic [3:0] level;
    logic any_level;
    logic sec_prot;
    logic sec_valid;
    logic cmd_ok;
    logic [31:0] rd_mux;

    // Level bits sit scattered in the status layout
    always_comb begin
        level = {prot_q[BIT_LEVEL3-BIT_LEVEL0], prot_q[BIT_LEVEL2-BIT_LEVEL0],
                 prot_q[BIT_LEVEL1-BIT_LEVEL0], prot_q[0]};
        any_level = level != 4'h0;
    end

    swp_range_dec u_dec (
        .density(dens_q),
        .top_bottom_select(prot_q[BIT_TOP_BOTTOM-BIT_LEVEL0]),
        .level(level),
        .sector(CMD_SECTOR),
        .sector_protected(sec_prot),
        .sector_valid(sec_valid)
    );

    // Command check, using the settings as they stand this cycle
    always_comb begin
        case (swp_kind_t'(CMD_KIND))
            KIND_WRITE_BYTE, KIND_SECTOR_ERASE: begin
                cmd_ok = sec_valid && !sec_prot; // see RQ9 see RQ11
            end
            KIND_BULK_ERASE, KIND_DIE_ERASE: begin
                cmd_ok = !any_level; // see RQ10
            end
            default: begin
                cmd_ok = 1'b0;
            end
        endcase
        accept_d = CMD_VALID && cmd_ok;
        reject_d = CMD_VALID && !cmd_ok;
        last_acc_d = CMD_VALID ? cmd_ok : last_acc_q;
        last_rej_d = CMD_VALID ? !cmd_ok : last_rej_q;
    end

    // Only the lowest 256 bytes hold registers; the rest of the space is unmapped
    function automatic logic low_page(input logic [31:0] addr);
        low_page = addr[31:8] == 24'h00_0000;
    endfunction

    // Configuration registers load in the data phase of a pending write
    always_comb begin
        prot_d = prot_q;
        dens_d = dens_q;
        if (wr_pend_q) begin
            if (wr_addr_q == OFS_PROT_CFG) begin
                prot_d = HWDATA[BIT_LEVEL3:BIT_LEVEL0];
            end else if (wr_addr_q == OFS_DENSITY) begin
                dens_d = HWDATA[1:0];
            end
        end
    end

    // Bus slave: zero wait states, always OKAY
    always_comb begin
        addr_phase = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == 2'h3);
        // Writes above the register page are dropped rather than aliased
        wr_pend_d = addr_phase && HWRITE && low_page(HADDR);
        wr_addr_d = addr_phase ? HADDR[7:0] : wr_addr_q;
        // Protect and density read data use next values so a read right after a write sees it
        rd_mux = 32'h0000_0000;
        if (low_page(HADDR)) begin
            case (HADDR[7:0])
                OFS_PROT_CFG: begin
                    rd_mux[BIT_LEVEL3:BIT_LEVEL0] = prot_d;
                end
                OFS_DENSITY: begin
                    rd_mux[1:0] = dens_d;
                end
                OFS_RESULT: begin
                    rd_mux[BIT_LAST_ACCEPT] = last_acc_q;
                    rd_mux[BIT_LAST_REJECT] = last_rej_q;
                    rd_mux[BIT_ANY_LEVEL] = any_level;
                end
                default: begin
                    rd_mux = 32'h0000_0000;
                end
            endcase
        end
        rdata_d = (addr_phase && !HWRITE) ? rd_mux : rdata_q;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            prot_q <= PROT_RST;
            dens_q <= DENSITY_RST;
        end else begin
            prot_q <= prot_d;
            dens_q <= dens_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b1;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
            ready_q <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            accept_q <= 1'b0;
            reject_q <= 1'b0;
            last_acc_q <= 1'b0;
            last_rej_q <= 1'b0;
        end else begin
            accept_q <= accept_d;
            reject_q <= reject_d;
            last_acc_q <= last_acc_d;
            last_rej_q <= last_rej_d;
        end
    end

    assign HRDATA = rdata_q;
    assign HREADYOUT = ready_q;
    assign HRESP = 1'b0;
    assign CMD_ACCEPT = accept_q;
    assign CMD_REJECT = reject_q;
endmodule

/* test/swp_protect_top_properties.sv */
// Port assertions for the sector write-protect decoder
`timescale 1ns/1ps
module swp_protect_properties
    import swp_pkg::*;
(
    input wire logic SYS_CLK, SYS_RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP,
    input wire logic [31:0] HADDR, HRDATA,
    input wire logic [1:0] HTRANS, CMD_KIND,
    input wire logic CMD_VALID, CMD_ACCEPT, CMD_REJECT,
    input wire logic [SECTOR_W-1:0] CMD_SECTOR
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    logic wrote_q;
    wire taken = HSEL && HREADY && HTRANS[1];
    // Until software writes anything the array stays unguarded
    always_ff @(posedge SYS_CLK) wrote_q <= !SYS_RST && (wrote_q || (taken && HWRITE));
    sequence cmd_s; CMD_VALID; endsequence
    sequence fresh_s; cmd_s and !wrote_q; endsequence
    a_one_answer: assert property (cmd_s |=> CMD_ACCEPT ^ CMD_REJECT)
        else $error("no single answer");
    a_no_stray: assert property (!CMD_VALID |=> !CMD_ACCEPT && !CMD_REJECT)
        else $error("stray answer");
    a_fresh_open: assert property ((fresh_s and (!CMD_KIND[1] && CMD_SECTOR < 7'h20)) |=> CMD_ACCEPT)
        else $error("free sector refused");
    a_bulk_open: assert property ((fresh_s and CMD_KIND[1]) |=> CMD_ACCEPT)
        else $error("bulk erase refused");
    a_fresh_range: assert property ((fresh_s and (!CMD_KIND[1] && CMD_SECTOR > 7'h1F)) |=> CMD_REJECT)
        else $error("sector beyond array taken");
    a_ready_okay: assert property (HREADYOUT && !HRESP)
        else $error("wait or error on bus");
    a_rd_hold: assert property (!(taken && !HWRITE) |=> $stable(HRDATA))
        else $error("read data moved");
    a_gap_zero: assert property (taken && !HWRITE && HADDR == 32'hC |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind swp_protect_top swp_protect_properties u_props (.SYS_CLK, .SYS_RST, .HSEL, .HWRITE,
    .HREADY, .HREADYOUT, .HRESP, .HADDR, .HRDATA, .HTRANS, .CMD_KIND, .CMD_VALID,
    .CMD_ACCEPT, .CMD_REJECT, .CMD_SECTOR);

/* test/swp_cmd_model.sv */
// Command issuer standing in for the flash write and erase logic
`timescale 1ns/1ps
module swp_cmd_model
    import swp_pkg::*;
(
    input wire logic clk,
    output logic vld,
    output logic [1:0] kind,
    output logic [SECTOR_W-1:0] sec
);
    initial begin
        vld = 1'b0;
        kind = 2'h0;
        sec = '0;
    end
    // Lines are inverted when idle so a stale value never passes for a request
    task automatic issue(input logic [1:0] k, input logic [SECTOR_W-1:0] s);
        vld <= 1'b1;
        kind <= k;
        sec <= s;
        @(posedge clk);
        vld <= 1'b0;
        kind <= ~k;
        sec <= ~s;
        @(posedge clk);
    endtask
endmodule

/* test/test_swp_protect_top.sv */
// Self-checking bench for the sector write-protect decoder
`timescale 1ns/1ps
module test_swp_protect_top;
    import swp_pkg::*;
    logic SYS_CLK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [1:0] HTRANS = 2'h0, CMD_KIND;
    logic HREADYOUT, HRESP, CMD_VALID, CMD_ACCEPT, CMD_REJECT;
    logic [SECTOR_W-1:0] CMD_SECTOR;
    int err_count = 0, cmp_count = 0, seed = 32'hC905;
    logic exp_q[$];
    always #25 SYS_CLK = ~SYS_CLK;
    swp_protect_top dut (.SYS_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
        .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .CMD_VALID, .CMD_KIND,
        .CMD_SECTOR, .CMD_ACCEPT, .CMD_REJECT);
    swp_cmd_model cmd (.clk(SYS_CLK), .vld(CMD_VALID), .kind(CMD_KIND), .sec(CMD_SECTOR));
    task automatic check(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 20);
        if (HREADYOUT !== 1'b1) begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        HSEL <= 1'b1;
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        HADDR <= a;
        wait_rdy();
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        rd = HRDATA;
    endtask
    function automatic int cnt_of(input int e, lv);
        int c;
        c = (e == 2) ? lv : lv % 8;
        return (c == 0) ? 0 : (c - 1 >= e + 5) ? (32 << e) : 1 << (c - 1);
    endfunction
    task automatic cmd_go(input int e, t, lv, k, s);
        int n;
        n = 32 << e;
        if (k >= 2) exp_q.push_back(lv == 0);
        else exp_q.push_back(s < n && (t ? s >= cnt_of(e, lv) : s < n - cnt_of(e, lv)));
        cmd.issue(k[1:0], s[SECTOR_W-1:0]);
    endtask
    // Each answer is matched against the oldest outstanding expectation
    always @(posedge SYS_CLK) begin
        if (CMD_ACCEPT === 1'b1 || CMD_REJECT === 1'b1) begin
            if (exp_q.size() == 0) check("unasked answer", 32'h0, 32'h1);
            else check("answer", exp_q.pop_front() ? 32'h2 : 32'h1, {CMD_ACCEPT, CMD_REJECT});
        end
    end
    initial begin
        int d, e, t, l, j, ed;
        logic [31:0] w;
        repeat (4) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        for (j = 0; j < 16; j += 4) begin
            bus(1'b0, j, 32'h0);
            check("reset word", 32'h0, rd);
        end
        for (j = 0; j < 8; j++) cmd_go(0, 0, 0, j % 4, j < 4 ? 31 : 127);
        $display("test reset done");
        for (d = 0; d < 4; d++) begin
            e = (d > 2) ? 2 : d;
            bus(1'b1, OFS_DENSITY, d);
            bus(1'b0, OFS_DENSITY, 32'h0);
            check("density", d, rd);
            for (t = 0; t < 2; t++) for (l = 0; l < 16; l++) begin
                w = $random(seed);
                w[6:2] = {l[3], t[0], l[2:0]};
                bus(1'b1, OFS_PROT_CFG, w);
                ed = t ? cnt_of(e, l) : (32 << e) - cnt_of(e, l);
                cmd_go(e, t, l, 0, (ed - 1) & 127);
                cmd_go(e, t, l, 1, ed & 127);
                cmd_go(e, t, l, $random(seed) & 1, $random(seed) & 127);
                cmd_go(e, t, l, 2 + l % 2, 0);
                bus(1'b0, OFS_RESULT, 32'h0);
                check("result", l ? 32'h6 : 32'h1, rd);
                bus(1'b0, OFS_PROT_CFG, 32'h0);
                check("protect word", w & 32'h7C, rd);
            end
            $display("test density %0d done", d);
        end
        repeat (3) @(posedge SYS_CLK);
        check("answers missing", 32'h0, exp_q.size());
        finish_test();
    end
endmodule
